// *** ccs_can_ctl_stat.sv ***
// Control and status register block of a CAN protocol controller
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps

module ccs_can_ctl_stat
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Wishbone classic slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [5:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // CAN pins and on-chip transceiver
    input wire logic i_bus_rx_in,
    input wire logic i_xcvr_rx,
    input wire logic i_xcvr_present,
    output logic o_bus_tx_out,
    output logic o_xcvr_tx,
    // Protocol engine side
    input wire logic i_tx_bit,
    input wire logic i_bit_tick,
    input wire logic i_rx_busy,
    input wire logic i_txbuf_empty,
    input wire logic i_bus_off,
    input wire logic i_frame_rx_ok,
    input wire logic i_frame_tx_ok,
    output logic o_init_abort,
    output logic o_bus_synchronized,
    output logic o_sleep_mode,
    output logic o_loopback,
    output logic o_listen,
    // Time stamp write port
    output logic o_ts_wr,
    output logic o_ts_rx,
    output logic [15:0] o_ts_value,
    // System wait mode
    input wire logic i_wait_mode,
    output logic o_if_clk_stop
);

    // ================================================================
    // Register map helpers

    // Writable bits of a stored configuration register
    function automatic logic [7:0] ccs_wmask(input logic [3:0] idx);
        case (idx)
            CCS_IDX_CTL1: ccs_wmask = CCS_MASK_CTL1;
            CCS_IDX_BTR0: ccs_wmask = CCS_MASK_FULL;
            CCS_IDX_BTR1: ccs_wmask = CCS_MASK_FULL;
            CCS_IDX_RIER: ccs_wmask = CCS_MASK_FULL;
            CCS_IDX_TIER: ccs_wmask = CCS_MASK_TX3;
            CCS_IDX_TARQ: ccs_wmask = CCS_MASK_TX3;
            CCS_IDX_TBSEL: ccs_wmask = CCS_MASK_TX3;
            CCS_IDX_IDAC: ccs_wmask = CCS_MASK_IDAC;
            CCS_IDX_MISC: ccs_wmask = CCS_MASK_MISC;
            default: ccs_wmask = CCS_MASK_NONE;
        endcase
    endfunction : ccs_wmask

    // Registers that only accept writes inside init mode
    function automatic logic ccs_init_only(input logic [3:0] idx);
        case (idx)
            CCS_IDX_CTL1: ccs_init_only = 1'b1;
            CCS_IDX_BTR0: ccs_init_only = 1'b1;
            CCS_IDX_BTR1: ccs_init_only = 1'b1;
            CCS_IDX_IDAC: ccs_init_only = 1'b1;
            default: ccs_init_only = 1'b0;
        endcase
    endfunction : ccs_init_only

    // ================================================================
    // Internal state
    logic [7:0] cfg_mem_reg [CCS_NUM_REGS];
    logic received_frame_flag_reg;
    logic receiver_active_reg;
    logic stop_in_wait_reg;
    logic time_reg;
    logic wakeup_enable_reg;
    logic sleep_request_reg;
    logic init_request_reg;
    logic init_acknowledge_reg;
    logic sleep_acknowledge_reg;
    ccs_sync_e sync_reg;
    logic [3:0] rec_cnt_reg;
    logic [7:0] run_cnt_reg;
    logic [15:0] timer_reg;
    logic rx_pin_meta_reg;
    logic rx_pin_reg;
    logic rx_xcvr_meta_reg;
    logic rx_xcvr_reg;

    logic [3:0] bus_idx;
    logic bus_req;
    logic bus_wr;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic init_mode;
    logic ctl0_open;
    logic wr_ctl0;
    logic rx_level;
    logic wake_hit;
    logic tx_force_rec;
    logic stamp_rx;

    // ================================================================
    // Bus decode: 64-byte window, one byte register per aligned word
    assign bus_idx = i_wb_adr[5:2];
    assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign bus_wr = bus_req & i_wb_we & i_wb_sel[0];
    assign wr_byte = i_wb_dat[7:0];
    assign wr_ctl0 = bus_wr & (bus_idx == CCS_IDX_CTL0);

    // Mode terms
    assign init_mode = init_request_reg & init_acknowledge_reg;
    assign ctl0_open = ~init_request_reg & ~init_acknowledge_reg;

    // Receive level from pin or on-chip transceiver, after synchronisers
    assign rx_level = i_xcvr_present ? rx_xcvr_reg : rx_pin_reg;

    // Bus traffic seen while asleep with wake-up enabled
    assign wake_hit = sleep_acknowledge_reg & wakeup_enable_reg & ~rx_level;

    // Transmit held recessive during init, sleep, listen or stopped wait
    assign tx_force_rec = init_request_reg | sleep_acknowledge_reg
        | cfg_mem_reg[CCS_IDX_CTL1][CCS_C1_LISTEN]
        | (stop_in_wait_reg & i_wait_mode);

    // Receive stamps are suppressed in loopback
    assign stamp_rx = i_frame_rx_ok
        & ~cfg_mem_reg[CCS_IDX_CTL1][CCS_C1_LOOPB];

    // ================================================================
    // Receive input synchronisers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rx_pin_meta_reg <= 1'b1;
            rx_pin_reg <= 1'b1;
            rx_xcvr_meta_reg <= 1'b1;
            rx_xcvr_reg <= 1'b1;
        end else begin
            rx_pin_meta_reg <= i_bus_rx_in;
            rx_pin_reg <= rx_pin_meta_reg;
            rx_xcvr_meta_reg <= i_xcvr_rx;
            rx_xcvr_reg <= rx_xcvr_meta_reg;
        end
    end

    // ================================================================
    // Read data mux
    always_comb begin
        rd_byte = CCS_RST_BYTE;
        case (bus_idx)
            CCS_IDX_CTL0: begin
                rd_byte[CCS_C0_RECEIVED_FRAME_FLAG] = received_frame_flag_reg;
                rd_byte[CCS_C0_RECEIVER_ACTIVE] = receiver_active_reg;
                rd_byte[CCS_C0_STOP_IN_WAIT] = stop_in_wait_reg;
                rd_byte[CCS_C0_BUS_SYNCHRONIZED] = (sync_reg == CCS_SYNC_DONE);
                rd_byte[CCS_C0_TIME] = time_reg;
                rd_byte[CCS_C0_WAKEUP_ENABLE] = wakeup_enable_reg;
                rd_byte[CCS_C0_SLEEP_REQUEST] = sleep_request_reg;
                rd_byte[CCS_C0_INIT_REQUEST] = init_request_reg;
            end
            CCS_IDX_CTL1: begin
                rd_byte = cfg_mem_reg[CCS_IDX_CTL1] & CCS_MASK_CTL1;
                rd_byte[1] = sleep_acknowledge_reg;
                rd_byte[0] = init_acknowledge_reg;
            end
            default: begin
                rd_byte = cfg_mem_reg[bus_idx] & ccs_wmask(bus_idx);
            end
        endcase
    end

    // Wishbone answer: one wait state, read data from a flop
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            if (bus_req) begin
                o_wb_dat <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ================================================================
    // Stored configuration registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            for (int i = 0; i < CCS_NUM_REGS; i++) begin
                cfg_mem_reg[i] <= CCS_RST_BYTE;
            end
        end else begin
            for (int i = 0; i < CCS_NUM_REGS; i++) begin
                if (!ccs_init_only(4'(i)) && init_mode) begin
                    cfg_mem_reg[i] <= CCS_RST_BYTE;
                end else if (bus_wr && bus_idx == 4'(i)
                    && (ccs_init_only(4'(i)) ? init_mode : ctl0_open)) begin
                    cfg_mem_reg[i] <= wr_byte & ccs_wmask(4'(i));
                end
            end
        end
    end

    // ================================================================
    // Init request and acknowledge
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            init_request_reg <= CCS_RST_INIT_REQUEST;
            init_acknowledge_reg <= CCS_RST_INIT_ACKNOWLEDGE;
            o_init_abort <= CCS_RST_INIT_REQUEST;
        end else begin
            // Set at any time; clear only once acknowledged
            if (wr_ctl0) begin
                if (wr_byte[CCS_C0_INIT_REQUEST]) begin
                    init_request_reg <= 1'b1;
                end else if (init_acknowledge_reg) begin
                    init_request_reg <= 1'b0;
                end
            end
            o_init_abort <= init_request_reg;
            init_acknowledge_reg <= init_request_reg & o_init_abort;
        end
    end

    // ================================================================
    // Sleep request, acknowledge and wake-up
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            sleep_request_reg <= 1'b0;
            sleep_acknowledge_reg <= 1'b0;
            wakeup_enable_reg <= 1'b0;
        end else begin
            if (wr_ctl0 && ctl0_open) begin
                wakeup_enable_reg <= wr_byte[CCS_C0_WAKEUP_ENABLE];
            end
            if (wake_hit) begin
                sleep_request_reg <= 1'b0;
            end else if (wr_ctl0 && ctl0_open) begin
                if (wr_byte[CCS_C0_SLEEP_REQUEST]) begin
                    sleep_request_reg <= 1'b1;
                end else if (sleep_acknowledge_reg) begin
                    sleep_request_reg <= 1'b0;
                end
            end
            // Grant only with nothing received and no pending transmit
            if (!sleep_request_reg || wake_hit) begin
                sleep_acknowledge_reg <= 1'b0;
            end else if (!i_rx_busy && i_txbuf_empty) begin
                sleep_acknowledge_reg <= 1'b1;
            end
        end
    end

    // ================================================================
    // Control zero flags held at reset value in init mode
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            received_frame_flag_reg <= 1'b0;
            receiver_active_reg <= 1'b0;
            stop_in_wait_reg <= 1'b0;
            time_reg <= 1'b0;
        end else if (init_mode) begin
            received_frame_flag_reg <= 1'b0;
            receiver_active_reg <= 1'b0;
            stop_in_wait_reg <= 1'b0;
            time_reg <= 1'b0;
        end else begin
            receiver_active_reg <= i_rx_busy;
            // Set wins over a clear in the same cycle
            if (i_frame_rx_ok && !cfg_mem_reg[CCS_IDX_CTL1][CCS_C1_LOOPB]) begin
                received_frame_flag_reg <= 1'b1;
            end else if (wr_ctl0 && ctl0_open && wr_byte[CCS_C0_RECEIVED_FRAME_FLAG]) begin
                received_frame_flag_reg <= 1'b0;
            end
            if (wr_ctl0 && ctl0_open) begin
                stop_in_wait_reg <= wr_byte[CCS_C0_STOP_IN_WAIT];
                time_reg <= wr_byte[CCS_C0_TIME];
            end
        end
    end

    // ================================================================
    // Bus synchronisation after init release
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            sync_reg <= CCS_SYNC_LOST;
            rec_cnt_reg <= 4'h0;
            run_cnt_reg <= 8'h00;
        end else begin
            case (sync_reg)
                CCS_SYNC_LOST: begin
                    rec_cnt_reg <= 4'h0;
                    run_cnt_reg <= 8'h00;
                    if (!init_request_reg && !init_acknowledge_reg) begin
                        sync_reg <= CCS_SYNC_HUNT;
                    end
                end
                CCS_SYNC_HUNT: begin
                    if (init_request_reg) begin
                        sync_reg <= CCS_SYNC_LOST;
                    end else if (i_bit_tick) begin
                        if (!rx_level) begin
                            rec_cnt_reg <= 4'h0;
                        end else if (rec_cnt_reg == CCS_REC_RUN - 4'h1) begin
                            rec_cnt_reg <= 4'h0;
                            run_cnt_reg <= run_cnt_reg + 8'h01;
                            if (!i_bus_off
                                || run_cnt_reg == CCS_BUSOFF_RUNS - 8'h01) begin
                                sync_reg <= CCS_SYNC_DONE;
                            end
                        end else begin
                            rec_cnt_reg <= rec_cnt_reg + 4'h1;
                        end
                    end
                end
                CCS_SYNC_DONE: begin
                    if (init_request_reg) begin
                        sync_reg <= CCS_SYNC_LOST;
                    end
                end
                default: begin
                    sync_reg <= CCS_SYNC_LOST;
                end
            endcase
        end
    end

    // ================================================================
    // Time-stamp timer and stamp write
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            timer_reg <= 16'h0000;
            o_ts_wr <= 1'b0;
            o_ts_rx <= 1'b0;
            o_ts_value <= 16'h0000;
        end else begin
            if (!time_reg) begin
                timer_reg <= 16'h0000;
            end else if (i_bit_tick) begin
                timer_reg <= timer_reg + CCS_TS_ONE;
            end
            o_ts_wr <= time_reg & (i_frame_tx_ok | stamp_rx);
            o_ts_rx <= stamp_rx & ~i_frame_tx_ok;
            if (time_reg && (i_frame_tx_ok || stamp_rx)) begin
                o_ts_value <= timer_reg;
            end
        end
    end

    // ================================================================
    // Pin drive and status outputs
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_bus_tx_out <= 1'b1;
            o_xcvr_tx <= 1'b1;
            o_if_clk_stop <= 1'b0;
            o_bus_synchronized <= 1'b0;
            o_sleep_mode <= 1'b0;
            o_loopback <= 1'b0;
            o_listen <= 1'b0;
        end else begin
            // Low is dominant, high is recessive
            o_bus_tx_out <= i_tx_bit | tx_force_rec
                | i_xcvr_present;
            o_xcvr_tx <= i_tx_bit | tx_force_rec;
            o_if_clk_stop <= stop_in_wait_reg & i_wait_mode;
            o_bus_synchronized <= (sync_reg == CCS_SYNC_DONE);
            o_sleep_mode <= sleep_acknowledge_reg;
            o_loopback <= cfg_mem_reg[CCS_IDX_CTL1][CCS_C1_LOOPB];
            o_listen <= cfg_mem_reg[CCS_IDX_CTL1][CCS_C1_LISTEN];
        end
    end

endmodule : ccs_can_ctl_stat

// *** ccs_ctl_stat_asserts.sv ***
// Concurrent checks on the control and status block ports
`timescale 1ns/1ps

module ccs_ctl_stat_asserts (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_xcvr_present,
    input wire logic i_tx_bit,
    input wire logic i_bit_tick,
    input wire logic i_rx_busy,
    input wire logic i_txbuf_empty,
    input wire logic i_frame_rx_ok,
    input wire logic i_frame_tx_ok,
    input wire logic o_bus_tx_out,
    input wire logic o_init_abort,
    input wire logic o_bus_synchronized,
    input wire logic o_sleep_mode,
    input wire logic o_loopback,
    input wire logic o_listen,
    input wire logic o_ts_wr,
    input wire logic o_ts_rx,
    input wire logic i_wait_mode,
    input wire logic o_if_clk_stop
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // =============================================
    // Helper: bit ticks seen since init was last released
    logic [3:0] tick_cnt;
    logic no_force;
    assign no_force = !o_init_abort && !o_sleep_mode && !o_listen &&
        !o_if_clk_stop && !i_xcvr_present;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || o_init_abort) begin
            tick_cnt <= 4'h0;
        end else if (i_bit_tick && tick_cnt != 4'hF) begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end
    // Two quiet cycles in a row let the engine bit through
    sequence s_quiet_two;
        no_force ##1 no_force;
    endsequence
    // =============================================
    a_tx_follows_bit: assert property (s_quiet_two |->
        o_bus_tx_out == $past(i_tx_bit)) else $error("tx pin mismatch");
    a_xcvr_route_pin: assert property (i_xcvr_present &&
        $past(i_xcvr_present) |-> o_bus_tx_out) else $error("pin not idle");
    a_wb_ack_one: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not one cycle");
    a_stop_needs_wait: assert property (o_if_clk_stop |->
        $past(i_wait_mode)) else $error("clock stop outside wait");
    a_sync_after_run: assert property ($rose(o_bus_synchronized) |->
        tick_cnt >= 4'hB) else $error("synchronized too early");
    a_init_drops_sync: assert property (o_init_abort |=>
        !o_bus_synchronized) else $error("sync kept in init");
    a_init_tx_idle: assert property (o_init_abort |->
        o_bus_tx_out) else $error("tx dominant in init");
    a_sleep_when_idle: assert property ($rose(o_sleep_mode) |->
        !$past(i_rx_busy, 2) && $past(i_txbuf_empty, 2))
        else $error("sleep granted while busy");
    a_stamp_has_cause: assert property (o_ts_wr |->
        $past(i_frame_rx_ok) || $past(i_frame_tx_ok))
        else $error("stamp without frame");
    a_no_loop_stamp: assert property (o_ts_wr && o_ts_rx |->
        !o_loopback) else $error("rx stamp in loopback");
endmodule : ccs_ctl_stat_asserts

bind ccs_can_ctl_stat ccs_ctl_stat_asserts ccs_chk_u (.*);

// *** ccs_pkg.sv ***
// Constants and types for the CAN controller control and status block
// =====================================================================
package ccs_pkg;

    // ================================================================
    // Register indexes (byte address is four times the index)
    localparam logic [3:0] CCS_IDX_CTL0 = 4'h0;
    localparam logic [3:0] CCS_IDX_CTL1 = 4'h1;
    localparam logic [3:0] CCS_IDX_BTR0 = 4'h2;
    localparam logic [3:0] CCS_IDX_BTR1 = 4'h3;
    localparam logic [3:0] CCS_IDX_RFLG = 4'h4;
    localparam logic [3:0] CCS_IDX_RIER = 4'h5;
    localparam logic [3:0] CCS_IDX_TFLG = 4'h6;
    localparam logic [3:0] CCS_IDX_TIER = 4'h7;
    localparam logic [3:0] CCS_IDX_TARQ = 4'h8;
    localparam logic [3:0] CCS_IDX_TAAK = 4'h9;
    localparam logic [3:0] CCS_IDX_TBSEL = 4'hA;
    localparam logic [3:0] CCS_IDX_IDAC = 4'hB;
    localparam logic [3:0] CCS_IDX_RSVD = 4'hC;
    localparam logic [3:0] CCS_IDX_MISC = 4'hD;
    localparam logic [3:0] CCS_IDX_RXERR = 4'hE;
    localparam int CCS_NUM_REGS = 16;

    // ================================================================
    // Control zero bit positions
    localparam int CCS_C0_RECEIVED_FRAME_FLAG = 7;
    localparam int CCS_C0_RECEIVER_ACTIVE = 6;
    localparam int CCS_C0_STOP_IN_WAIT = 5;
    localparam int CCS_C0_BUS_SYNCHRONIZED = 4;
    localparam int CCS_C0_TIME = 3;
    localparam int CCS_C0_WAKEUP_ENABLE = 2;
    localparam int CCS_C0_SLEEP_REQUEST = 1;
    localparam int CCS_C0_INIT_REQUEST = 0;

    // Control one bit positions
    localparam int CCS_C1_LOOPB = 5;
    localparam int CCS_C1_LISTEN = 4;

    // ================================================================
    // Writable masks of stored configuration registers
    localparam logic [7:0] CCS_MASK_CTL1 = 8'hFC;
    localparam logic [7:0] CCS_MASK_FULL = 8'hFF;
    localparam logic [7:0] CCS_MASK_TX3 = 8'h07;
    localparam logic [7:0] CCS_MASK_IDAC = 8'h30;
    localparam logic [7:0] CCS_MASK_MISC = 8'h01;
    localparam logic [7:0] CCS_MASK_NONE = 8'h00;

    // Reset values
    localparam logic [7:0] CCS_RST_BYTE = 8'h00;
    localparam logic CCS_RST_INIT_REQUEST = 1'b1;
    localparam logic CCS_RST_INIT_ACKNOWLEDGE = 1'b1;

    // ================================================================
    // Synchronisation counts and time-stamp increment
    localparam logic [3:0] CCS_REC_RUN = 4'hB;
    localparam logic [7:0] CCS_BUSOFF_RUNS = 8'h80;
    localparam logic [15:0] CCS_TS_ONE = 16'h0001;

    // Bus synchronisation states
    typedef enum logic [1:0] {
        CCS_SYNC_LOST = 2'b00,
        CCS_SYNC_HUNT = 2'b01,
        CCS_SYNC_DONE = 2'b10
    } ccs_sync_e;

endpackage : ccs_pkg

// *** ccs_xcvr_model.sv ***
// Behavioural transceiver and shared bus seen by the control block
`timescale 1ns/1ps

module ccs_xcvr_model (
    // Transmit sources
    input wire logic i_tx_pin,
    input wire logic i_tx_xcvr,
    input wire logic i_xcvr_present,
    // Another station driving dominant
    input wire logic i_drive_dom,
    // Bus level back to the receiver
    output logic o_rx
);
    // =============================================
    // Wired-and bus: a low level is dominant
    assign o_rx = (i_xcvr_present ? i_tx_xcvr : i_tx_pin) & ~i_drive_dom;
endmodule : ccs_xcvr_model

// *** tb_can_controller_control_status.sv ***
// Self-checking testbench of the control and status block
`timescale 1ns/1ps

module tb_can_controller_control_status;
    import ccs_pkg::*;
    logic i_clk_sys = 1'b0, i_resetn = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [5:0] i_wb_adr = 6'h00;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
    logic [3:0] i_wb_sel = 4'h0;
    logic o_wb_ack, i_bus_rx_in, o_bus_tx_out, o_xcvr_tx, o_ts_wr, o_ts_rx;
    logic i_xcvr_present = 1'b0, i_tx_bit = 1'b1, i_bit_tick = 1'b0;
    logic i_rx_busy = 1'b0, i_txbuf_empty = 1'b1, i_bus_off = 1'b0;
    logic i_frame_rx_ok = 1'b0, i_frame_tx_ok = 1'b0, i_wait_mode = 1'b0;
    logic dom = 1'b0;
    logic o_init_abort, o_bus_synchronized, o_sleep_mode, o_loopback;
    logic o_listen, o_if_clk_stop;
    logic [15:0] o_ts_value;
    int n_errors = 0, checked = 0;
    // =============================================
    // Design, far-side model and clock
    ccs_can_ctl_stat dut_u (.*, .i_xcvr_rx(i_bus_rx_in));
    ccs_xcvr_model xcvr_u (.i_tx_pin(o_bus_tx_out), .i_tx_xcvr(o_xcvr_tx),
        .i_xcvr_present(i_xcvr_present), .i_drive_dom(dom),
        .o_rx(i_bus_rx_in));
    always #12.5 i_clk_sys = ~i_clk_sys;
    // =============================================
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] idx,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_sel <= 4'hF;
        i_wb_adr <= {idx, 2'b00};
        i_wb_dat <= {24'h000000, d};
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        q = o_wb_dat[7:0];
        if (n >= 20) n_errors++;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk({24'h000000, q}, {24'h000000, e});
    endtask : rd
    task automatic ticks(input int n);
        @(posedge i_clk_sys);
        i_bit_tick <= 1'b1;
        repeat (n) @(posedge i_clk_sys);
        i_bit_tick <= 1'b0;
    endtask : ticks
    task automatic frame(input logic rx, input logic [15:0] exp);
        @(posedge i_clk_sys);
        i_frame_rx_ok <= rx;
        i_frame_tx_ok <= !rx;
        @(posedge i_clk_sys);
        i_frame_rx_ok <= 1'b0;
        i_frame_tx_ok <= 1'b0;
        @(posedge i_clk_sys);
        chk(o_ts_wr, 1'b1);
        chk(o_ts_value, exp);
        chk(o_ts_rx, rx);
    endtask : frame
    task automatic stop_test;
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // =============================================
    // Scenarios
    task automatic t_reset;
        rd(CCS_IDX_CTL0, 8'h01);
        rd(CCS_IDX_CTL1, 8'h01);
        rd(CCS_IDX_RSVD, 8'h00);
        wr(CCS_IDX_CTL0, 8'h2D);
        rd(CCS_IDX_CTL0, 8'h01);
    endtask : t_reset
    task automatic t_sync;
        wr(CCS_IDX_CTL0, 8'h00);
        rd(CCS_IDX_CTL1, 8'h00);
        ticks(10);
        repeat (3) @(posedge i_clk_sys);
        chk(o_bus_synchronized, 1'b0);
        ticks(1);
        repeat (3) @(posedge i_clk_sys);
        chk(o_bus_synchronized, 1'b1);
        wr(CCS_IDX_CTL0, 8'hD0);
        rd(CCS_IDX_CTL0, 8'h10);
        i_rx_busy <= 1'b1;
        rd(CCS_IDX_CTL0, 8'h50);
        i_rx_busy <= 1'b0;
    endtask : t_sync
    task automatic t_stamp;
        wr(CCS_IDX_CTL0, 8'h08);
        ticks(5);
        frame(1'b0, 16'h0005);
        wr(CCS_IDX_CTL0, 8'h00);
        wr(CCS_IDX_CTL0, 8'h08);
        ticks(2);
        frame(1'b1, 16'h0002);
        rd(CCS_IDX_CTL0, 8'h98);
        wr(CCS_IDX_CTL0, 8'h18);
        rd(CCS_IDX_CTL0, 8'h98);
        wr(CCS_IDX_CTL0, 8'h98);
        rd(CCS_IDX_CTL0, 8'h18);
        ticks(65539);
        frame(1'b0, 16'h0005);
        wr(CCS_IDX_CTL0, 8'h00);
    endtask : t_stamp
    task automatic t_pins;
        i_tx_bit <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk(o_bus_tx_out, 1'b0);
        i_xcvr_present <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk({o_bus_tx_out, o_xcvr_tx}, 2'b10);
        i_xcvr_present <= 1'b0;
        wr(CCS_IDX_CTL0, 8'h20);
        i_wait_mode <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk({o_if_clk_stop, o_bus_tx_out}, 2'b11);
        i_wait_mode <= 1'b0;
        wr(CCS_IDX_CTL0, 8'h00);
        i_wait_mode <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk({o_if_clk_stop, o_bus_tx_out}, 2'b00);
        i_wait_mode <= 1'b0;
        i_tx_bit <= 1'b1;
    endtask : t_pins
    task automatic t_sleep(input logic wake);
        int n;
        i_rx_busy <= 1'b1;
        wr(CCS_IDX_CTL0, {5'h00, wake, 2'b00});
        wr(CCS_IDX_CTL0, {5'h00, wake, 2'b10});
        repeat (4) @(posedge i_clk_sys);
        chk(o_sleep_mode, 1'b0);
        i_rx_busy <= 1'b0;
        n = 0;
        while (o_sleep_mode !== 1'b1 && n < 50) begin
            @(posedge i_clk_sys);
            n++;
        end
        rd(CCS_IDX_CTL1, 8'h02);
        dom <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        dom <= 1'b0;
        chk(o_sleep_mode, !wake);
        wr(CCS_IDX_CTL0, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        chk(o_sleep_mode, 1'b0);
    endtask : t_sleep
    task automatic t_init;
        i_tx_bit <= 1'b0;
        wr(CCS_IDX_CTL0, 8'h09);
        @(posedge i_clk_sys);
        chk(o_init_abort, 1'b1);
        rd(CCS_IDX_CTL1, 8'h01);
        chk({o_bus_synchronized, o_bus_tx_out}, 2'b01);
        rd(CCS_IDX_CTL0, 8'h01);
    endtask : t_init
    // Loopback and listen set in init, then bus-off resync
    task automatic t_loop;
        wr(CCS_IDX_CTL1, 8'h30);
        rd(CCS_IDX_CTL1, 8'h31);
        chk({o_loopback, o_listen}, 2'b11);
        wr(CCS_IDX_CTL0, 8'h00);
        wr(CCS_IDX_CTL0, 8'h08);
        i_frame_rx_ok <= 1'b1;
        @(posedge i_clk_sys);
        i_frame_rx_ok <= 1'b0;
        @(posedge i_clk_sys);
        chk(o_ts_wr, 1'b0);
        rd(CCS_IDX_CTL0, 8'h08);
        i_bus_off <= 1'b1;
        ticks(1407);
        repeat (3) @(posedge i_clk_sys);
        chk(o_bus_synchronized, 1'b0);
        ticks(1);
        repeat (3) @(posedge i_clk_sys);
        chk(o_bus_synchronized, 1'b1);
        i_bus_off <= 1'b0;
    endtask : t_loop
    // =============================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        t_reset();
        t_sync();
        t_stamp();
        t_pins();
        t_sleep(1'b1);
        t_sleep(1'b0);
        t_init();
        t_loop();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge i_clk_sys);
        n_errors++;
        stop_test();
    end
endmodule : tb_can_controller_control_status
